// ### rtl/dbr_debug_buffer_address_regs.sv
// debug holding buffer, debug address register and tap byte link
// assumes tap state strobes arrive on tck; sys_rst synchronous on mclk
// Functional notes
// - flag register bits 7:2 read zero
// - buffer clears on reset or test-logic-reset
// - buffer is eight bits, cpu read/write
// - buffer loads and unloads tap shift register
// - buffer sits in cpu sfr space
// - address register sets to all ones
// - address sixteen bits, cpu writes ignored
// - address loads only through debug command
// - transfer complete flag set per tap data transfer, not by address commands
// - address masks register breakpoint data compare
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// fifo
module dbr_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [W-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [PW:0] wrPtr_q;
    logic [PW:0] wrPtr_d;
    logic [PW:0] rdPtr_q;
    logic [PW:0] rdPtr_d;
    logic push;
    logic pop;

    assign inReady = (wrPtr_q[PW-1:0] != rdPtr_q[PW-1:0]) || (wrPtr_q[PW] == rdPtr_q[PW]);
    assign outValid = wrPtr_q != rdPtr_q;
    assign outData = mem_q[rdPtr_q[PW-1:0]];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb
    begin
        wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
        rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end
        else
        begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wrPtr_q[PW-1:0]] <= inData;
        end
    end
endmodule

// ==========================================
// top
module dbr_debug_buffer_address_regs #(
    parameter int FIFO_DEPTH = dbr_pkg::FIFO_DEPTH
) (
    // system clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // cpu sfr port
    input wire logic [dbr_pkg::SFR_AW-1:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic [dbr_pkg::ADDR_W-1:0] sfrWrData,
    output logic [dbr_pkg::ADDR_W-1:0] sfrRdData,
    // register breakpoint compare
    input wire logic regBrkActive,
    input wire logic [dbr_pkg::ADDR_W-1:0] dbgDataReg,
    input wire logic [dbr_pkg::ADDR_W-1:0] updData,
    output logic regBrkHit,
    // tap link
    input wire logic tck,
    input wire logic tapTlr,
    input wire logic tapCapture,
    input wire logic tapShift,
    input wire logic tapUpdate,
    input wire logic tapAddrCmd,
    input wire logic tdi,
    output logic tdo
);
    localparam int DW = dbr_pkg::DATA_W;
    localparam int AW = dbr_pkg::ADDR_W;

    // ==========================================
    // mclk side state
    logic tlrS1_q;
    logic tlrS2_q;
    logic rxS1_q;
    logic rxS2_q;
    logic rxAck_q;
    logic rxAck_d;
    logic txAckS1_q;
    logic txAckS2_q;
    logic txTgl_q;
    logic txTgl_d;
    logic [DW-1:0] txHold_q;
    logic [DW-1:0] txHold_d;
    logic [DW-1:0] buf_q;
    logic [DW-1:0] buf_d;
    logic [AW-1:0] addr_q;
    logic [AW-1:0] addr_d;
    logic txc_q;
    logic txc_d;
    logic [AW-1:0] rd_q;
    logic [AW-1:0] rd_d;
    logic brk_q;
    logic brk_d;
    logic mRst;
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [DW:0] fifoOutData;
    logic push;
    logic pop;

    // ==========================================
    // tck side state
    logic [DW-1:0] sh_q;
    logic [DW-1:0] sh_d;
    logic [DW:0] rxWord_q;
    logic [DW:0] rxWord_d;
    logic rxTgl_q;
    logic rxTgl_d;
    logic rxAckS1_q;
    logic rxAckS2_q;
    logic txS1_q;
    logic txS2_q;
    logic txSeen_q;
    logic txSeen_d;
    logic [DW-1:0] tckBuf_q;
    logic [DW-1:0] tckBuf_d;
    logic tdo_q;
    logic tdo_d;

    assign mRst = sys_rst || tlrS2_q;
    assign push = (rxS2_q != rxAck_q) && fifoInReady;
    assign pop = fifoOutValid && fifoOutReady;
    assign fifoOutReady = fifoOutData[DW] || !txc_q;
    assign sfrRdData = rd_q;
    assign regBrkHit = brk_q;
    assign tdo = tdo_q;

    // ==========================================
    // crossing synchronisers on mclk
    always_ff @(posedge mclk)
    begin
        tlrS1_q <= tapTlr;
        tlrS2_q <= tlrS1_q;
        rxS1_q <= rxTgl_q;
        rxS2_q <= rxS1_q;
        txAckS1_q <= txSeen_q;
        txAckS2_q <= txAckS1_q;
    end

    // ==========================================
    // received byte fifo
    dbr_fifo #(
        .W(DW + 1),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .rst(mRst),
        .inValid(rxS2_q != rxAck_q),
        .inReady(fifoInReady),
        .inData(rxWord_q),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );

    // ==========================================
    // registers on mclk
    always_comb
    begin
        rxAck_d = push ? rxS2_q : rxAck_q;
        buf_d = buf_q;
        addr_d = addr_q;
        txc_d = txc_q;
        txHold_d = txHold_q;
        txTgl_d = txTgl_q;
        if (sfrWrEn && sfrAddr == dbr_pkg::OFS_BUF)
        begin
            buf_d = sfrWrData[DW-1:0];
        end
        if (sfrWrEn && sfrAddr == dbr_pkg::OFS_FLAG)
        begin
            txc_d = sfrWrData[dbr_pkg::FLAG_TXC_BIT];
        end
        if (pop && fifoOutData[DW])
        begin
            addr_d = {addr_q[DW-1:0], fifoOutData[DW-1:0]};
        end
        else if (pop)
        begin
            buf_d = fifoOutData[DW-1:0];
            txc_d = 1'b1;
        end
        if (txTgl_q == txAckS2_q && txHold_q != buf_q)
        begin
            txHold_d = buf_q;
            txTgl_d = !txTgl_q;
        end
        brk_d = regBrkActive && (((dbgDataReg ^ updData) & addr_q) == '0);
        rd_d = '0;
        unique case (sfrAddr)
            dbr_pkg::OFS_FLAG: rd_d[DW-1:0] = {dbr_pkg::FLAG_RSVD, dbr_pkg::FLAG_SPE, txc_q};
            dbr_pkg::OFS_BUF: rd_d[DW-1:0] = buf_q;
            dbr_pkg::OFS_ADDR: rd_d = addr_q;
            default: rd_d = '0;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (mRst)
        begin
            buf_q <= dbr_pkg::BUF_RST;
            addr_q <= dbr_pkg::ADDR_RST;
            txc_q <= 1'b0;
            rxAck_q <= 1'b0;
            txHold_q <= dbr_pkg::BUF_RST;
            txTgl_q <= 1'b0;
            rd_q <= '0;
            brk_q <= 1'b0;
        end
        else
        begin
            buf_q <= buf_d;
            addr_q <= addr_d;
            txc_q <= txc_d;
            rxAck_q <= rxAck_d;
            txHold_q <= txHold_d;
            txTgl_q <= txTgl_d;
            rd_q <= rd_d;
            brk_q <= brk_d;
        end
    end

    // ==========================================
    // crossing synchronisers on tck
    always_ff @(posedge tck)
    begin
        rxAckS1_q <= rxAck_q;
        rxAckS2_q <= rxAckS1_q;
        txS1_q <= txTgl_q;
        txS2_q <= txS1_q;
    end

    // ==========================================
    // tap shift register on tck
    always_comb
    begin
        sh_d = sh_q;
        rxWord_d = rxWord_q;
        rxTgl_d = rxTgl_q;
        txSeen_d = txSeen_q;
        tckBuf_d = tckBuf_q;
        if (txS2_q != txSeen_q)
        begin
            tckBuf_d = txHold_q;
            txSeen_d = txS2_q;
        end
        if (tapCapture)
        begin
            sh_d = tckBuf_q;
        end
        else if (tapShift)
        begin
            sh_d = {tdi, sh_q[DW-1:1]};
        end
        if (tapUpdate && rxTgl_q == rxAckS2_q)
        begin
            rxWord_d = {tapAddrCmd, sh_q};
            rxTgl_d = !rxTgl_q;
        end
        tdo_d = sh_d[0];
    end

    always_ff @(posedge tck)
    begin
        if (tapTlr)
        begin
            sh_q <= dbr_pkg::BUF_RST;
            rxWord_q <= '0;
            rxTgl_q <= rxAckS2_q;
            txSeen_q <= txS2_q;
            tckBuf_q <= dbr_pkg::BUF_RST;
            tdo_q <= 1'b0;
        end
        else
        begin
            sh_q <= sh_d;
            rxWord_q <= rxWord_d;
            rxTgl_q <= rxTgl_d;
            txSeen_q <= txSeen_d;
            tckBuf_q <= tckBuf_d;
            tdo_q <= tdo_d;
        end
    end
endmodule

`default_nettype wire

// ### rtl/dbr_pkg.sv
// constants for the debug holding buffer and debug address registers
// assumes an sfr port on mclk and a tap link on its own test clock
package dbr_pkg;
    // ==========================================
    // widths and depths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int SFR_AW = 5;
    localparam int FIFO_DEPTH = 32;
    // ==========================================
    // sfr offsets
    localparam logic [4:0] OFS_FLAG = 5'h1b;
    localparam logic [4:0] OFS_BUF = 5'h1c;
    localparam logic [4:0] OFS_ADDR = 5'h1d;
    // ==========================================
    // reset values and fields
    localparam logic [7:0] BUF_RST = 8'h00;
    localparam logic [15:0] ADDR_RST = 16'hffff;
    localparam logic [5:0] FLAG_RSVD = 6'h00;
    localparam logic FLAG_SPE = 1'h0;
    localparam int FLAG_TXC_BIT = 0;
endpackage

// ### test/dbr_sva.sv
// checker on the top module ports
// assumes it is bound to the top module
`timescale 1ns/100ps
`default_nettype none
module dbr_sva (
    // clocks and reset
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic tck,
    // sfr port
    input wire logic [4:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic [15:0] sfrRdData,
    // breakpoint
    input wire logic regBrkActive,
    input wire logic [15:0] dbgDataReg,
    input wire logic [15:0] updData,
    input wire logic regBrkHit,
    // tap
    input wire logic tapTlr,
    input wire logic tapUpdate
);
    logic updT;
    logic updP;
    logic [3:0] quiet;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge tck)
        updT <= !tapTlr && (updT ^ tapUpdate);
    always_ff @(posedge mclk)
    begin
        updP <= updT;
        quiet <= (sys_rst || tapTlr || updT != updP || (sfrWrEn && sfrAddr == 5'h1b)) ? 4'h0
            : quiet + 4'(quiet != 4'hf);
    end
    sequence tlrDone;
        tapTlr [*5] ##1 (!tapTlr && !sfrWrEn) [*5];
    endsequence
    // ==========================================
    // assertions
    rsvd_zero_a: assert property ($past(sfrAddr) == 5'h1b |-> sfrRdData[15:1] == 15'h0)
        else $error("flag bits");
    buf_width_a: assert property ($past(sfrAddr) == 5'h1c |-> sfrRdData[15:8] == 8'h00)
        else $error("buffer width");
    unmapped_zero_a: assert property (!($past(sfrAddr) inside {[5'h1b:5'h1d]}) |-> sfrRdData == 16'h0)
        else $error("unmapped read");
    addr_ro_a: assert property (quiet == 4'hf && $past(sfrAddr) == 5'h1d && $past(sfrAddr, 2) == 5'h1d
        |-> $stable(sfrRdData)) else $error("address moved");
    buf_tlr_a: assert property (tlrDone ##0 $past(sfrAddr) == 5'h1c |-> sfrRdData == 16'h0000)
        else $error("buffer reset");
    addr_tlr_a: assert property (tlrDone ##0 $past(sfrAddr) == 5'h1d |-> sfrRdData == 16'hffff)
        else $error("address reset");
    brk_off_a: assert property (!regBrkActive ##1 1'b1 |-> !regBrkHit)
        else $error("hit while off");
    brk_eq_a: assert property (quiet > 4'h4 && regBrkActive && dbgDataReg == updData |=> regBrkHit)
        else $error("no hit");
endmodule
bind dbr_debug_buffer_address_regs dbr_sva u_sva (.mclk, .sys_rst, .tck, .sfrAddr, .sfrWrEn, .sfrRdData,
    .regBrkActive, .dbgDataReg, .updData, .regBrkHit, .tapTlr, .tapUpdate);
`default_nettype wire

// ### test/dbr_jtag_host.sv
// tap host model, tck runs only within frames
// assumes tdo shows shift register bit0
`timescale 1ns/100ps
`default_nettype none
module dbr_jtag_host (
    // tap link
    output logic tck,
    output logic tapTlr,
    output logic tapCapture,
    output logic tapShift,
    output logic tapUpdate,
    output logic tapAddrCmd,
    output logic tdi,
    input wire logic tdo
);
    initial
    begin
        {tck, tapCapture, tapShift, tapUpdate, tapAddrCmd, tdi} = 6'h00;
        tapTlr = 1'b1;
    end
    task automatic tick;
        #16 tck = 1'b1;
        #16 tck = 1'b0;
    endtask
    task automatic reset_tap;
        tapTlr = 1'b1;
        repeat (8) tick();
        tapTlr = 1'b0;
        // idle ticks so the mclk side leaves reset before the first access
        repeat (4) tick();
    endtask
    task automatic xfer(input logic [7:0] b, input logic cmd, output logic [7:0] got);
        // idle ticks carry a new buffer value across to the capture stage
        repeat (4) tick();
        tapCapture = 1'b1;
        tick();
        tapCapture = 1'b0;
        tapShift = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            got[i] = tdo;
            tdi = b[i];
            tick();
        end
        tapShift = 1'b0;
        tdi = !tdi;
        tapAddrCmd = cmd;
        tapUpdate = 1'b1;
        tick();
        tapUpdate = 1'b0;
        repeat (8) tick();
    endtask
endmodule
`default_nettype wire

// ### test/dbr_debug_buffer_address_regs_tb.sv
// bench for the debug buffer and address registers
// assumes the host model and checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module dbr_debug_buffer_address_regs_tb;
    logic mclk, sys_rst, sfrWrEn, regBrkActive, regBrkHit;
    logic tck, tapTlr, tapCapture, tapShift, tapUpdate, tapAddrCmd, tdi, tdo;
    logic [4:0] sfrAddr;
    logic [15:0] sfrWrData, sfrRdData, dbgDataReg, updData;
    logic [7:0] got;
    logic [17:0] brkCase [4] = '{18'h201ff, 18'h203ff, 18'h205fe, 18'h001fe};
    int n_errors = 0;
    int n_compared = 0;
    dbr_debug_buffer_address_regs u_dut (.mclk, .sys_rst, .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdData,
        .regBrkActive, .dbgDataReg, .updData, .regBrkHit, .tck, .tapTlr, .tapCapture, .tapShift,
        .tapUpdate, .tapAddrCmd, .tdi, .tdo);
    dbr_jtag_host u_host (.tck, .tapTlr, .tapCapture, .tapShift, .tapUpdate, .tapAddrCmd, .tdi, .tdo);
    task automatic end_sim;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk) #1;
        sfrAddr = a;
        sfrWrData = d;
        sfrWrEn = 1'b1;
        @(posedge mclk) #1;
        sfrWrEn = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge mclk) #1;
        sfrAddr = a;
        @(posedge mclk) #1;
        chk($sformatf("sfr %h", a), exp, sfrRdData);
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial
    begin
        #60000;
        n_errors++;
        end_sim();
    end
    initial
    begin
        {sys_rst, sfrWrEn, regBrkActive} = 3'h4;
        {sfrAddr, sfrWrData, dbgDataReg, updData} = 53'h0;
        repeat (3) @(posedge mclk);
        #1 sys_rst = 1'b0;
        u_host.reset_tap();
        rd(5'h1c, 16'h0000);
        rd(5'h1d, 16'hffff);
        rd(5'h1b, 16'h0000);
        wr(5'h1c, 16'hffa5);
        rd(5'h1c, 16'h00a5);
        wr(5'h1d, 16'h1234);
        rd(5'h1d, 16'hffff);
        wr(5'h1b, 16'hfffe);
        rd(5'h1b, 16'h0000);
        rd(5'h1f, 16'h0000);
        repeat (10) @(posedge mclk);
        u_host.xfer(8'h3c, 1'b0, got);
        chk("tdo byte", 16'h00a5, {8'h00, got});
        u_host.xfer(8'hc3, 1'b0, got);
        chk("tdo byte", 16'h003c, {8'h00, got});
        rd(5'h1c, 16'h003c);
        rd(5'h1b, 16'h0001);
        wr(5'h1b, 16'h0000);
        repeat (10) @(posedge mclk);
        rd(5'h1c, 16'h00c3);
        wr(5'h1b, 16'h0000);
        for (int i = 0; i < 2; i++)
        begin
            u_host.xfer(i ? 8'h34 : 8'h12, 1'b1, got);
            repeat (10) @(posedge mclk);
            wr(5'h1b, 16'h0000);
        end
        repeat (16) @(posedge mclk);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk) #1;
            {regBrkActive, updData} = brkCase[i][17:1];
            dbgDataReg = 16'h00ff;
            @(posedge mclk) #1;
            chk("break hit", {15'h0, brkCase[i][0]}, {15'h0, regBrkHit});
        end
        regBrkActive = 1'b0;
        wr(5'h1d, 16'h5555);
        rd(5'h1d, 16'h1234);
        u_host.reset_tap();
        rd(5'h1d, 16'hffff);
        rd(5'h1c, 16'h0000);
        u_host.reset_tap();
        rd(5'h1c, 16'h0000);
        end_sim();
    end
endmodule
`default_nettype wire
